// file: common/fpc_pkg.sv
// constants and types shared by both ends of the protection command bus
package fpc_pkg;
	// ---------------------------------------------------------------
	// geometry
	// ---------------------------------------------------------------
	localparam int ADDR_W = 24;
	localparam int SECTOR_LSB = 14;
	localparam int BANK_LSB = 20;
	localparam int PAGE_LSB = 5;
	localparam int CMD_ADDR_W = 14;
	// ---------------------------------------------------------------
	// command addresses and data
	// ---------------------------------------------------------------
	localparam logic [13:0] UNLOCK_ADDR1 = 14'h0555;
	localparam logic [13:0] UNLOCK_ADDR2 = 14'h02AA;
	localparam logic [7:0] UNLOCK_DATA1 = 8'hAA;
	localparam logic [7:0] UNLOCK_DATA2 = 8'h55;
	localparam logic [7:0] MODE_PERSIST = 8'hC0;
	localparam logic [7:0] MODE_FREEZE = 8'h50;
	localparam logic [7:0] MODE_VOLATILE = 8'hE0;
	localparam logic [7:0] MODE_PASSWORD = 8'h60;
	localparam logic [7:0] EXIT_DATA1 = 8'h90;
	localparam logic [7:0] EXIT_DATA2 = 8'h00;
	localparam logic [7:0] CMD_SET = 8'hA0;
	localparam logic [7:0] CMD_ERASE = 8'h80;
	localparam logic [7:0] CMD_ERASE_CONFIRM = 8'h30;
	localparam logic [7:0] CMD_BUF_LOAD = 8'h25;
	localparam logic [7:0] CMD_BUF_COMMIT = 8'h29;
	localparam logic [7:0] CMD_RESET = 8'hF0;
	localparam logic [7:0] PROT_SET_DATA = 8'h00;
	localparam logic [7:0] PROT_CLEAR_DATA = 8'h01;
	// ---------------------------------------------------------------
	// types
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		PROT_PERSIST = 2'b00,
		PROT_FREEZE = 2'b01,
		PROT_VOLATILE = 2'b10,
		PROT_PASSWORD = 2'b11
	} fpc_prot_t;
	typedef enum logic [2:0] {
		OP_READ = 3'b000,
		OP_WRITE = 3'b001,
		OP_ENTER = 3'b010,
		OP_EXIT = 3'b011,
		OP_BUF_START = 3'b100,
		OP_BUF_LOAD = 3'b101,
		OP_COMMIT = 3'b110,
		OP_RESET = 3'b111
	} fpc_op_t;
endpackage : fpc_pkg

// file: common/fpc_bus_if.sv
// multiplexed burst bus between host controller and flash decoder
`timescale 1ns/10ps
interface fpc_bus_if #(parameter int ADDR_W = fpc_pkg::ADDR_W);
	logic [ADDR_W-17:0] addr_hi;
	logic [15:0] host_dq;
	logic host_dq_oe;
	logic [15:0] dev_dq;
	logic dev_dq_oe;
	logic address_valid_strobe_n;
	logic chip_enable_n;
	logic write_enable_n;
	logic output_enable_n;
	logic burst_clock;
	logic [15:0] dq;
	// resolved wire level, pulled high when nobody drives
	assign dq = dev_dq_oe ? dev_dq : (host_dq_oe ? host_dq : 16'hFFFF);
	modport host (output addr_hi, host_dq, host_dq_oe, address_valid_strobe_n, chip_enable_n,
		write_enable_n, output_enable_n, burst_clock, input dq);
	modport device (input addr_hi, address_valid_strobe_n, chip_enable_n, write_enable_n,
		output_enable_n, burst_clock, dq, output dev_dq, dev_dq_oe);
endinterface : fpc_bus_if

// file: logic/fpc_device.sv
// flash protection command decoder, device end
// Operation
// - entry is AA, 55, then mode code
// - exit is 90 then 00, any address
// - only exit leaves the protection set
// - status read drives line zero low if protected
// - address latched on strobe rise or clock
// - data latched on write or select rise
// - sector taken from top bits to A14
// - bank taken from top bits to A20
// - buffer load: 25, count, address/data pairs
// - host keeps loads inside one page
// - 29 to sector commits the buffer
// - A1..A0 pick the password quarter
// - command cycles are writes, status are reads
// - upper data byte ignored in commands
// - address bits from A14 up ignored
// - host resets after a bad sequence
// - array reads need no command cycles
// - read data changes on clock rising edge
`timescale 1ns/10ps
module fpc_device #(
	parameter int ADDR_W = fpc_pkg::ADDR_W,
	parameter int CNT_W = fpc_pkg::PAGE_LSB
) (
	input wire logic clock_i,
	input wire logic rst_i,
	fpc_bus_if.device bus,
	output logic [ADDR_W-1:0] array_addr_o,
	input wire logic [15:0] array_data_i,
	output logic prog_valid_o,
	output logic [ADDR_W-1:0] prog_addr_o,
	output logic [15:0] prog_data_o,
	output logic erase_valid_o,
	output logic [ADDR_W-fpc_pkg::SECTOR_LSB-1:0] erase_sector_o,
	output logic buf_commit_o,
	output logic buf_abort_o,
	output logic prot_active_o,
	output logic [ADDR_W-fpc_pkg::BANK_LSB-1:0] prot_bank_o
);
	localparam int SEC_W = ADDR_W - fpc_pkg::SECTOR_LSB;
	localparam int SECTORS = 1 << SEC_W;
	localparam int PG_W = ADDR_W - fpc_pkg::PAGE_LSB;

	typedef enum logic [3:0] {
		ST_ARRAY = 4'h0,
		ST_UNLK1 = 4'h1,
		ST_UNLK2 = 4'h2,
		ST_PROT = 4'h3,
		ST_PROT_EXIT = 4'h4,
		ST_PROT_SET = 4'h5,
		ST_PROT_ERASE = 4'h6,
		ST_ACC_PROG = 4'h7,
		ST_ACC_ERASE = 4'h8,
		ST_BUF_COUNT = 4'h9,
		ST_BUF_LOAD = 4'hA,
		ST_BUF_COMMIT = 4'hB
	} fpc_dev_state_t;

	// ---------------------------------------------------------------
	// pin sampling and cycle capture
	// ---------------------------------------------------------------
	logic avd_prev, we_prev, ce_prev, clk_prev, addr_taken;
	logic [15:0] dq_prev;
	logic [ADDR_W-1:0] addr_lat;
	logic [15:0] data_lat;
	logic wr_evt;
	logic addr_evt, data_evt, clk_rise;

	assign clk_rise = bus.burst_clock && !clk_prev;
	assign addr_evt = !addr_taken && ((!avd_prev && bus.address_valid_strobe_n) ||
		(clk_rise && !bus.address_valid_strobe_n));
	assign data_evt = !we_prev && !ce_prev && (bus.write_enable_n || bus.chip_enable_n);

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			avd_prev <= 1'b1;
			we_prev <= 1'b1;
			ce_prev <= 1'b1;
			clk_prev <= 1'b0;
			dq_prev <= 16'h0000;
		end else begin
			avd_prev <= bus.address_valid_strobe_n;
			we_prev <= bus.write_enable_n;
			ce_prev <= bus.chip_enable_n;
			clk_prev <= bus.burst_clock;
			dq_prev <= bus.dq;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			addr_taken <= 1'b0;
			addr_lat <= '0;
		end else if (addr_evt) begin
			addr_taken <= 1'b1;
			addr_lat <= {bus.addr_hi, bus.dq};
		end else if (avd_prev && !bus.address_valid_strobe_n) begin
			addr_taken <= 1'b0;
		end
	end

	// only write strobes carry commands
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			wr_evt <= 1'b0;
			data_lat <= 16'h0000;
		end else begin
			wr_evt <= data_evt;
			if (data_evt) begin
				data_lat <= dq_prev;
			end
		end
	end

	// ---------------------------------------------------------------
	// command decode
	// ---------------------------------------------------------------
	fpc_dev_state_t state;
	fpc_pkg::fpc_prot_t mode;
	logic [7:0] wd;
	logic [13:0] wa;
	logic [SEC_W-1:0] wsec, buf_sector;
	logic [PG_W-1:0] buf_page;
	logic [CNT_W-1:0] buf_left;
	logic buf_first;
	logic freeze;
	logic [SECTORS-1:0] persistent_protect_bit;
	logic [SECTORS-1:0] dynamic_protect_bit;
	logic [15:0] password_word [4];

	assign wd = data_lat[7:0];
	assign wa = addr_lat[fpc_pkg::CMD_ADDR_W-1:0];
	assign wsec = addr_lat[ADDR_W-1:fpc_pkg::SECTOR_LSB];

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			state <= ST_ARRAY;
			mode <= fpc_pkg::PROT_PERSIST;
			prot_bank_o <= '0;
		end else if (wr_evt) begin
			unique case (state)
				ST_ARRAY: begin
					if (wa == fpc_pkg::UNLOCK_ADDR1 && wd == fpc_pkg::UNLOCK_DATA1) begin
						state <= ST_UNLK1;
					end else if (wa == fpc_pkg::UNLOCK_ADDR1 && wd == fpc_pkg::CMD_SET) begin
						state <= ST_ACC_PROG;
					end else if (wa == fpc_pkg::UNLOCK_ADDR1 && wd == fpc_pkg::CMD_ERASE) begin
						state <= ST_ACC_ERASE;
					end else if (wd == fpc_pkg::CMD_BUF_LOAD) begin
						state <= ST_BUF_COUNT;
					end
				end
				ST_UNLK1: begin
					state <= (wa == fpc_pkg::UNLOCK_ADDR2 && wd == fpc_pkg::UNLOCK_DATA2) ? ST_UNLK2 : ST_ARRAY;
				end
				ST_UNLK2: begin
					state <= ST_ARRAY;
					if (wa == fpc_pkg::UNLOCK_ADDR1) begin
						prot_bank_o <= addr_lat[ADDR_W-1:fpc_pkg::BANK_LSB];
						state <= ST_PROT;
						unique case (wd)
							fpc_pkg::MODE_PERSIST: mode <= fpc_pkg::PROT_PERSIST;
							fpc_pkg::MODE_FREEZE: mode <= fpc_pkg::PROT_FREEZE;
							fpc_pkg::MODE_VOLATILE: mode <= fpc_pkg::PROT_VOLATILE;
							fpc_pkg::MODE_PASSWORD: mode <= fpc_pkg::PROT_PASSWORD;
							default: state <= ST_ARRAY;
						endcase
					end
				end
				ST_PROT: begin
					if (wd == fpc_pkg::EXIT_DATA1) begin
						state <= ST_PROT_EXIT;
					end else if (wd == fpc_pkg::CMD_SET) begin
						state <= ST_PROT_SET;
					end else if (wd == fpc_pkg::CMD_ERASE && mode == fpc_pkg::PROT_PERSIST) begin
						state <= ST_PROT_ERASE;
					end
				end
				ST_PROT_EXIT: begin
					state <= (wd == fpc_pkg::EXIT_DATA2) ? ST_ARRAY : ST_PROT;
				end
				ST_PROT_SET, ST_PROT_ERASE: state <= ST_PROT;
				ST_ACC_PROG, ST_ACC_ERASE: state <= ST_ARRAY;
				ST_BUF_COUNT: state <= (wsec == buf_sector) ? ST_BUF_LOAD : ST_ARRAY;
				ST_BUF_LOAD: begin
					if (!buf_first && addr_lat[ADDR_W-1:fpc_pkg::PAGE_LSB] != buf_page) begin
						state <= ST_ARRAY;
					end else if (buf_left == '0) begin
						state <= ST_BUF_COMMIT;
					end
				end
				ST_BUF_COMMIT: state <= ST_ARRAY;
				default: state <= ST_ARRAY;
			endcase
		end
	end

	// buffer bookkeeping
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			buf_sector <= '0;
			buf_page <= '0;
			buf_left <= '0;
			buf_first <= 1'b0;
		end else if (wr_evt) begin
			if (state == ST_ARRAY) begin
				buf_sector <= wsec;
			end
			if (state == ST_BUF_COUNT) begin
				buf_left <= data_lat[CNT_W-1:0];
				buf_first <= 1'b1;
			end
			if (state == ST_BUF_LOAD) begin
				buf_first <= 1'b0;
				buf_left <= buf_left - 1'b1;
				if (buf_first) begin
					buf_page <= addr_lat[ADDR_W-1:fpc_pkg::PAGE_LSB];
				end
			end
		end
	end

	// user side strobes
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			prog_valid_o <= 1'b0;
			prog_addr_o <= '0;
			prog_data_o <= 16'h0000;
			erase_valid_o <= 1'b0;
			erase_sector_o <= '0;
			buf_commit_o <= 1'b0;
			buf_abort_o <= 1'b0;
		end else begin
			prog_valid_o <= 1'b0;
			erase_valid_o <= 1'b0;
			buf_commit_o <= 1'b0;
			buf_abort_o <= 1'b0;
			if (wr_evt) begin
				if (state == ST_ACC_PROG || (state == ST_BUF_LOAD &&
					(buf_first || addr_lat[ADDR_W-1:fpc_pkg::PAGE_LSB] == buf_page))) begin
					prog_valid_o <= 1'b1;
					prog_addr_o <= addr_lat;
					prog_data_o <= data_lat;
				end
				if (state == ST_ACC_ERASE && wd == fpc_pkg::CMD_ERASE_CONFIRM) begin
					erase_valid_o <= 1'b1;
					erase_sector_o <= wsec;
				end
				if (state == ST_BUF_COMMIT) begin
					buf_commit_o <= (wd == fpc_pkg::CMD_BUF_COMMIT && wsec == buf_sector);
					buf_abort_o <= !(wd == fpc_pkg::CMD_BUF_COMMIT && wsec == buf_sector);
				end
				if ((state == ST_BUF_COUNT && wsec != buf_sector) || (state == ST_BUF_LOAD && !buf_first &&
					addr_lat[ADDR_W-1:fpc_pkg::PAGE_LSB] != buf_page)) begin
					buf_abort_o <= 1'b1;
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// protection bits and password
	// ---------------------------------------------------------------
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			persistent_protect_bit <= '0;
			dynamic_protect_bit <= '0;
			freeze <= 1'b0;
			for (int i = 0; i < 4; i++) begin
				password_word[i] <= 16'h0000;
			end
		end else if (wr_evt && state == ST_PROT_SET) begin
			unique case (mode)
				fpc_pkg::PROT_PERSIST: begin
					if (!freeze && wd == fpc_pkg::PROT_SET_DATA) begin
						persistent_protect_bit[wsec] <= 1'b1;
					end
				end
				fpc_pkg::PROT_FREEZE: begin
					if (wd == fpc_pkg::PROT_SET_DATA) begin
						freeze <= 1'b1;
					end
				end
				fpc_pkg::PROT_VOLATILE: begin
					if (wd == fpc_pkg::PROT_SET_DATA) begin
						dynamic_protect_bit[wsec] <= 1'b1;
					end else if (wd == fpc_pkg::PROT_CLEAR_DATA) begin
						dynamic_protect_bit[wsec] <= 1'b0;
					end
				end
				fpc_pkg::PROT_PASSWORD: password_word[addr_lat[1:0]] <= data_lat;
			endcase
		end else if (wr_evt && state == ST_PROT_ERASE && wd == fpc_pkg::CMD_ERASE_CONFIRM && !freeze) begin
			persistent_protect_bit <= '0;
		end
	end

	// ---------------------------------------------------------------
	// read path
	// ---------------------------------------------------------------
	logic in_prot;
	logic [15:0] next_dq;
	logic [15:0] dev_dq;

	assign in_prot = state inside {ST_PROT, ST_PROT_EXIT, ST_PROT_SET, ST_PROT_ERASE};
	assign prot_active_o = in_prot;
	assign array_addr_o = addr_lat;

	always_comb begin
		next_dq = array_data_i;
		if (in_prot) begin
			unique case (mode)
				fpc_pkg::PROT_PERSIST: next_dq = {15'h0000, !persistent_protect_bit[wsec]};
				fpc_pkg::PROT_FREEZE: next_dq = {15'h0000, !freeze};
				fpc_pkg::PROT_VOLATILE: next_dq = {15'h0000, !dynamic_protect_bit[wsec]};
				fpc_pkg::PROT_PASSWORD: next_dq = password_word[addr_lat[1:0]];
			endcase
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			dev_dq <= 16'h0000;
		end else if (clk_rise) begin
			dev_dq <= next_dq;
		end
	end

	assign bus.dev_dq = dev_dq;
	assign bus.dev_dq_oe = !bus.chip_enable_n && !bus.output_enable_n && bus.write_enable_n;
endmodule : fpc_device

// file: logic/fpc_host.sv
// host controller end of the protection command bus
`timescale 1ns/10ps
module fpc_host #(
	parameter int ADDR_W = fpc_pkg::ADDR_W
) (
	input wire logic clock_i,
	input wire logic rst_i,
	fpc_bus_if.host bus,
	input wire logic cmd_valid_i,
	output logic cmd_ready_o,
	input wire fpc_pkg::fpc_op_t cmd_op_i,
	input wire logic [ADDR_W-1:0] cmd_addr_i,
	input wire logic [15:0] cmd_data_i,
	output logic resp_valid_o,
	output logic resp_error_o,
	output logic [15:0] resp_data_o,
	output logic prot_active_o
);
	localparam int PG_W = ADDR_W - fpc_pkg::PAGE_LSB;

	typedef enum logic [2:0] {
		H_IDLE = 3'h0,
		H_ADDR = 3'h1,
		H_ALAT = 3'h2,
		H_ACT = 3'h3,
		H_HOLD = 3'h4,
		H_END = 3'h5,
		H_TAIL = 3'h6
	} fpc_host_state_t;

	fpc_host_state_t state;
	fpc_pkg::fpc_op_t op;
	logic [ADDR_W-1:0] op_addr;
	logic [15:0] op_data;
	logic [1:0] step, last_step;
	logic [ADDR_W-1:0] cyc_addr;
	logic [15:0] cyc_data;
	logic buf_first;
	logic [PG_W-1:0] buf_page;
	logic page_bad;

	// ---------------------------------------------------------------
	// sequence expansion
	// ---------------------------------------------------------------
	always_comb begin
		cyc_addr = op_addr;
		cyc_data = op_data;
		last_step = 2'd0;
		unique case (op)
			fpc_pkg::OP_ENTER: begin
				last_step = 2'd2;
				cyc_data = (step == 2'd0) ? {8'h00, fpc_pkg::UNLOCK_DATA1} :
					(step == 2'd1) ? {8'h00, fpc_pkg::UNLOCK_DATA2} : op_data;
				cyc_addr = {op_addr[ADDR_W-1:fpc_pkg::CMD_ADDR_W],
					(step == 2'd1) ? fpc_pkg::UNLOCK_ADDR2 : fpc_pkg::UNLOCK_ADDR1};
			end
			fpc_pkg::OP_EXIT: begin
				last_step = 2'd1;
				cyc_data = {8'h00, (step == 2'd0) ? fpc_pkg::EXIT_DATA1 : fpc_pkg::EXIT_DATA2};
			end
			fpc_pkg::OP_BUF_START: begin
				last_step = 2'd1;
				cyc_data = (step == 2'd0) ? {8'h00, fpc_pkg::CMD_BUF_LOAD} : op_data;
			end
			fpc_pkg::OP_COMMIT: cyc_data = {8'h00, fpc_pkg::CMD_BUF_COMMIT};
			fpc_pkg::OP_RESET: cyc_data = {8'h00, fpc_pkg::CMD_RESET};
			fpc_pkg::OP_READ, fpc_pkg::OP_WRITE, fpc_pkg::OP_BUF_LOAD: begin
				cyc_data = op_data;
			end
		endcase
	end

	assign page_bad = cmd_op_i == fpc_pkg::OP_BUF_LOAD && !buf_first &&
		cmd_addr_i[ADDR_W-1:fpc_pkg::PAGE_LSB] != buf_page;
	assign cmd_ready_o = state == H_IDLE;

	// ---------------------------------------------------------------
	// cycle engine
	// ---------------------------------------------------------------
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			state <= H_IDLE;
			op <= fpc_pkg::OP_READ;
			op_addr <= '0;
			op_data <= 16'h0000;
			step <= 2'd0;
			resp_valid_o <= 1'b0;
			resp_error_o <= 1'b0;
			resp_data_o <= 16'h0000;
		end else begin
			resp_valid_o <= 1'b0;
			resp_error_o <= 1'b0;
			unique case (state)
				H_IDLE: begin
					if (cmd_valid_i && page_bad) begin
						resp_valid_o <= 1'b1;
						resp_error_o <= 1'b1;
					end else if (cmd_valid_i) begin
						op <= cmd_op_i;
						op_addr <= cmd_addr_i;
						op_data <= cmd_data_i;
						step <= 2'd0;
						state <= H_ADDR;
					end
				end
				H_ADDR: state <= H_ALAT;
				H_ALAT: state <= H_ACT;
				H_ACT: state <= H_HOLD;
				H_HOLD: state <= H_END;
				H_END: begin
					if (op == fpc_pkg::OP_READ) begin
						resp_data_o <= bus.dq;
					end
					state <= H_TAIL;
				end
				H_TAIL: begin
					if (step == last_step) begin
						resp_valid_o <= 1'b1;
						state <= H_IDLE;
					end else begin
						step <= step + 2'd1;
						state <= H_ADDR;
					end
				end
				default: state <= H_IDLE;
			endcase
		end
	end

	// buffer page and protection mode tracking
	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			buf_first <= 1'b0;
			buf_page <= '0;
			prot_active_o <= 1'b0;
		end else if (state == H_IDLE && cmd_valid_i && !page_bad) begin
			if (cmd_op_i == fpc_pkg::OP_BUF_START) begin
				buf_first <= 1'b1;
			end else if (cmd_op_i == fpc_pkg::OP_BUF_LOAD && buf_first) begin
				buf_first <= 1'b0;
				buf_page <= cmd_addr_i[ADDR_W-1:fpc_pkg::PAGE_LSB];
			end
			if (cmd_op_i == fpc_pkg::OP_ENTER) begin
				prot_active_o <= 1'b1;
			end else if (cmd_op_i == fpc_pkg::OP_EXIT) begin
				prot_active_o <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// pin drive
	// ---------------------------------------------------------------
	logic rd;
	assign rd = op == fpc_pkg::OP_READ;
	assign bus.addr_hi = cyc_addr[ADDR_W-1:16];
	assign bus.address_valid_strobe_n = state != H_ADDR;
	assign bus.chip_enable_n = state == H_IDLE || state == H_TAIL;
	assign bus.write_enable_n = rd || !(state == H_ACT || state == H_HOLD);
	assign bus.output_enable_n = !rd || !(state inside {H_ACT, H_HOLD, H_END});
	assign bus.burst_clock = rd && state == H_ACT;
	assign bus.host_dq = (state == H_ADDR || state == H_ALAT) ? cyc_addr[15:0] : cyc_data;
	assign bus.host_dq_oe = (state == H_ADDR || state == H_ALAT) || (!rd && state inside {H_ACT, H_HOLD, H_END});
endmodule : fpc_host

// file: verification/fpc_bus_assertions.sv
// bus protocol assertions for the protection command bus
`timescale 1ns/10ps
module fpc_bus_assertions (
	input wire logic clock_i,
	input wire logic rst_i,
	input wire logic host_dq_oe,
	input wire logic [15:0] dev_dq,
	input wire logic dev_dq_oe,
	input wire logic address_valid_strobe_n,
	input wire logic chip_enable_n,
	input wire logic write_enable_n,
	input wire logic output_enable_n,
	input wire logic burst_clock
);
	// ------------------------------------------------------------
	// bus cycle checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clock_i);
	endclocking
	default disable iff (rst_i);
	single_driver_a: assert property (!(host_dq_oe && dev_dq_oe))
		else $error("both ends drive dq");
	read_drive_a: assert property (dev_dq_oe == (!chip_enable_n && !output_enable_n && write_enable_n))
		else $error("device drive outside a read cycle");
	no_rw_overlap_a: assert property (!(!write_enable_n && !output_enable_n))
		else $error("write and read strobes overlap");
	strobe_selected_a: assert property (!address_valid_strobe_n |-> !chip_enable_n)
		else $error("address strobe without select");
	strobe_pulse_a: assert property ($fell(address_valid_strobe_n) |=> address_valid_strobe_n)
		else $error("address strobe longer than one cycle");
	write_pulse_a: assert property ($fell(write_enable_n) |=>
		!write_enable_n ##1 write_enable_n ##1 chip_enable_n)
		else $error("write strobe shape wrong");
	read_edge_a: assert property (!$rose(burst_clock) |=> $stable(dev_dq))
		else $error("read data changed without clock rise");
	clock_pulse_a: assert property ($rose(burst_clock) |-> !output_enable_n ##1 !burst_clock)
		else $error("burst clock outside read or too long");
	cycle_release_a: assert property ($rose(chip_enable_n) |-> !host_dq_oe && output_enable_n)
		else $error("bus not released at cycle end");
	cover_read_c: cover property ($rose(burst_clock));
endmodule : fpc_bus_assertions

// file: verification/tb_top.sv
// self-checking bench for the host and device ends joined by the bus
`timescale 1ns/10ps
module tb_top;
	// ------------------------------------------------------------
	// clock, reset and ends
	// ------------------------------------------------------------
	logic clock_i = 1'h0;
	logic rst_i = 1'h1;
	logic cmd_valid = 1'h0;
	fpc_pkg::fpc_op_t cmd_op = fpc_pkg::OP_READ;
	logic [23:0] cmd_addr = 24'h00_0000;
	logic [15:0] cmd_data = 16'h0000;
	logic cmd_ready, resp_valid, resp_error, host_prot, dev_prot;
	logic [15:0] resp_data, array_data, prog_data, rd;
	logic [23:0] array_addr, prog_addr;
	logic prog_valid, erase_valid, buf_commit, buf_abort, rerr;
	logic [9:0] erase_sector;
	logic [3:0] prot_bank;
	int errors = 0;
	int checks = 0;
	int cycles = 0;
	int prog_n = 0;
	int erase_n = 0;
	int commit_n = 0;
	int abort_n = 0;
	always #5 clock_i = ~clock_i;
	assign array_data = array_addr[15:0] ^ 16'h5A5A;
	fpc_bus_if bus_if ();
	fpc_host fpc_host_i (.clock_i(clock_i), .rst_i(rst_i), .bus(bus_if.host), .cmd_valid_i(cmd_valid),
		.cmd_ready_o(cmd_ready), .cmd_op_i(cmd_op), .cmd_addr_i(cmd_addr), .cmd_data_i(cmd_data),
		.resp_valid_o(resp_valid), .resp_error_o(resp_error), .resp_data_o(resp_data), .prot_active_o(host_prot));
	fpc_device fpc_device_i (.clock_i(clock_i), .rst_i(rst_i), .bus(bus_if.device), .array_addr_o(array_addr),
		.array_data_i(array_data), .prog_valid_o(prog_valid), .prog_addr_o(prog_addr), .prog_data_o(prog_data),
		.erase_valid_o(erase_valid), .erase_sector_o(erase_sector), .buf_commit_o(buf_commit),
		.buf_abort_o(buf_abort), .prot_active_o(dev_prot), .prot_bank_o(prot_bank));
	fpc_bus_assertions fpc_bus_assertions_i (.clock_i(clock_i), .rst_i(rst_i), .host_dq_oe(bus_if.host_dq_oe),
		.dev_dq(bus_if.dev_dq), .dev_dq_oe(bus_if.dev_dq_oe), .address_valid_strobe_n(bus_if.address_valid_strobe_n),
		.chip_enable_n(bus_if.chip_enable_n), .write_enable_n(bus_if.write_enable_n),
		.output_enable_n(bus_if.output_enable_n), .burst_clock(bus_if.burst_clock));
	// ------------------------------------------------------------
	// monitor and timeout
	// ------------------------------------------------------------
	always @(posedge clock_i) begin
		cycles++;
		if (prog_valid === 1'h1) prog_n++;
		if (erase_valid === 1'h1) erase_n++;
		if (buf_commit === 1'h1) commit_n++;
		if (buf_abort === 1'h1) abort_n++;
		if (cycles == 20000) begin
			errors++;
			summarize();
		end
	end
	// ------------------------------------------------------------
	// shared tasks
	// ------------------------------------------------------------
	task summarize();
		$display("checks=%0d errors=%0d", checks, errors);
		if (errors == 0 && checks > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : summarize
	task chk(input logic [23:0] got, input logic [23:0] exp);
		checks++;
		if (got !== exp) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task run(input fpc_pkg::fpc_op_t op, input logic [23:0] a, input logic [15:0] d);
		int n;
		@(posedge clock_i);
		cmd_valid <= 1'h1;
		cmd_op <= op;
		cmd_addr <= a;
		cmd_data <= d;
		n = 0;
		do begin
			@(posedge clock_i);
			n++;
		end while (cmd_ready !== 1'h1 && n < 60);
		cmd_valid <= 1'h0;
		n = 0;
		while (resp_valid !== 1'h1 && n < 60) begin
			@(posedge clock_i);
			n++;
		end
		if (resp_valid !== 1'h1) begin
			errors++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, resp_valid, 1'h1);
		end
		rd = resp_data;
		rerr = resp_error;
		repeat (2) @(posedge clock_i);
		@(negedge clock_i);
	endtask : run
	// ------------------------------------------------------------
	// scenarios
	// ------------------------------------------------------------
	task t_read();
		run(fpc_pkg::OP_READ, 24'h12_3456, 16'h0000);
		chk(24'(rd), 24'h00_6E0C);
		chk(24'(rerr), 24'h00_0000);
	endtask : t_read
	task t_modes();
		logic [7:0] codes [3];
		codes[0] = 8'hC0;
		codes[1] = 8'h50;
		codes[2] = 8'hE0;
		for (int i = 0; i < 3; i++) begin
			run(fpc_pkg::OP_ENTER, {4'(i + 9), 20'h0_0000}, {8'hFF, codes[i]});
			chk(24'(dev_prot), 24'h00_0001);
			chk(24'(host_prot), 24'h00_0001);
			chk(24'(prot_bank), 24'(i + 9));
			run(fpc_pkg::OP_RESET, 24'h00_0000, 16'h00F0);
			chk(24'(dev_prot), 24'h00_0001);
			run(fpc_pkg::OP_EXIT, 24'h3C_1234, 16'h0000);
			chk(24'(dev_prot), 24'h00_0000);
		end
	endtask : t_modes
	task t_status();
		run(fpc_pkg::OP_ENTER, 24'h00_0000, 16'h00E0);
		run(fpc_pkg::OP_WRITE, 24'h00_0000, 16'hFFA0);
		run(fpc_pkg::OP_WRITE, 24'h0A_4000, 16'hFF00);
		run(fpc_pkg::OP_READ, 24'h0A_5234, 16'h0000);
		chk(24'(rd), 24'h00_0000);
		run(fpc_pkg::OP_READ, 24'h0A_0000, 16'h0000);
		chk(24'(rd), 24'h00_0001);
		run(fpc_pkg::OP_WRITE, 24'h00_0000, 16'h00A0);
		run(fpc_pkg::OP_WRITE, 24'h0A_4000, 16'h0001);
		run(fpc_pkg::OP_READ, 24'h0A_4000, 16'h0000);
		chk(24'(rd), 24'h00_0001);
		run(fpc_pkg::OP_EXIT, 24'h00_0000, 16'h0000);
	endtask : t_status
	task t_program();
		int p0, e0;
		p0 = prog_n;
		e0 = erase_n;
		run(fpc_pkg::OP_WRITE, 24'hFF_C555, 16'h00A0);
		run(fpc_pkg::OP_WRITE, 24'h31_2345, 16'hBEEF);
		chk(24'(prog_n - p0), 24'h00_0001);
		chk(prog_addr, 24'h31_2345);
		chk(24'(prog_data), 24'h00_BEEF);
		run(fpc_pkg::OP_WRITE, 24'hFF_C555, 16'h0080);
		run(fpc_pkg::OP_WRITE, 24'h31_2345, 16'h0030);
		chk(24'(erase_n - e0), 24'h00_0001);
		chk(24'(erase_sector), 24'h00_00C4);
	endtask : t_program
	task t_buffer();
		int p0, c0, a0;
		p0 = prog_n;
		c0 = commit_n;
		a0 = abort_n;
		run(fpc_pkg::OP_BUF_START, 24'h20_4000, 16'h0001);
		run(fpc_pkg::OP_BUF_LOAD, 24'h20_4003, 16'h1111);
		run(fpc_pkg::OP_BUF_LOAD, 24'h20_4004, 16'h2222);
		run(fpc_pkg::OP_COMMIT, 24'h20_4000, 16'h0029);
		chk(24'(prog_n - p0), 24'h00_0002);
		chk(24'(commit_n - c0), 24'h00_0001);
		run(fpc_pkg::OP_BUF_START, 24'h20_4000, 16'h0001);
		run(fpc_pkg::OP_BUF_LOAD, 24'h20_4000, 16'h3333);
		run(fpc_pkg::OP_BUF_LOAD, 24'h20_4020, 16'h4444);
		chk(24'(rerr), 24'h00_0001);
		run(fpc_pkg::OP_RESET, 24'h00_0000, 16'h00F0);
		chk(24'(abort_n - a0), 24'h00_0001);
		run(fpc_pkg::OP_READ, 24'h00_0777, 16'h0000);
		chk(24'(rd), 24'h00_5D2D);
	endtask : t_buffer
	task t_password();
		run(fpc_pkg::OP_ENTER, 24'h00_0000, 16'h0060);
		for (int q = 0; q < 4; q++) begin
			run(fpc_pkg::OP_WRITE, 24'h00_0000, 16'h00A0);
			run(fpc_pkg::OP_WRITE, 24'(q), 16'(16'hC3A0 + q));
		end
		for (int q = 0; q < 4; q++) begin
			run(fpc_pkg::OP_READ, 24'(q), 16'h0000);
			chk(24'(rd), 24'(16'hC3A0 + q));
		end
		run(fpc_pkg::OP_EXIT, 24'h00_0000, 16'h0000);
		chk(24'(dev_prot), 24'h00_0000);
	endtask : t_password
	task t_persist();
		run(fpc_pkg::OP_ENTER, 24'h00_0000, 16'h00C0);
		run(fpc_pkg::OP_WRITE, 24'h00_0000, 16'h00A0);
		run(fpc_pkg::OP_WRITE, 24'h0A_4000, 16'h0000);
		run(fpc_pkg::OP_READ, 24'h0A_4000, 16'h0000);
		chk(24'(rd), 24'h00_0000);
		run(fpc_pkg::OP_WRITE, 24'h00_0000, 16'h0080);
		run(fpc_pkg::OP_WRITE, 24'h00_0000, 16'h0030);
		run(fpc_pkg::OP_READ, 24'h0A_4000, 16'h0000);
		chk(24'(rd), 24'h00_0001);
		run(fpc_pkg::OP_EXIT, 24'h00_0000, 16'h0000);
		run(fpc_pkg::OP_ENTER, 24'h00_0000, 16'h0050);
		run(fpc_pkg::OP_WRITE, 24'h00_0000, 16'h00A0);
		run(fpc_pkg::OP_WRITE, 24'h00_0000, 16'h0000);
		run(fpc_pkg::OP_READ, 24'h00_0000, 16'h0000);
		chk(24'(rd), 24'h00_0000);
		run(fpc_pkg::OP_EXIT, 24'h00_0000, 16'h0000);
		chk(24'(dev_prot), 24'h00_0000);
	endtask : t_persist
	initial begin
		repeat (4) @(posedge clock_i);
		rst_i <= 1'h0;
		t_read();
		t_modes();
		t_status();
		t_program();
		t_buffer();
		t_password();
		t_persist();
		summarize();
	end
endmodule : tb_top
